// file: rtl/plc_regs.svh
// plc_regs.svh: constants of the pll loop mode control block
// assumes: included by bare name from package and design modules
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH

// clock rate of ref_clk_i
`define PLC_CLK_HZ      25000000
// multiplier, range and linear field widths
`define PLC_N_W         12
`define PLC_E_W         2
`define PLC_L_W         8
// lock detector: reference cycles per window and tolerances in feedback counts
`define PLC_LD_WINDOW   5'h10
`define PLC_LD_LAST     5'h0F
`define PLC_ACQ_TOL     8'h03
`define PLC_LOCK_TOL    8'h01
`define PLC_FB_MAX      8'hFF
// nominal center frequency in units of 100 Hz (71.4 kHz)
`define PLC_FNOM_HZ100  21'h0002CA
`define PLC_CTR_W       21
// base clock is the source over 2, bus clock the source over 4
`define PLC_BASE_DIV    12'h002
`define PLC_BUS_DIV     12'h004

`endif

// file: rtl/plc_pkg.sv
// plc_pkg: types of the pll loop mode control block
// assumes: plc_regs.svh is on the include path
`include "plc_regs.svh"
package plc_pkg;

  // lock detector states, one-hot
  typedef enum logic [3:0] {
    PLC_LD_OFF     = 4'h1,
    PLC_LD_ACQUIRE = 4'h2,
    PLC_LD_TRACK   = 4'h4,
    PLC_LD_LOCKED  = 4'h8
  } plc_ld_state_e;

  // software control bits
  typedef struct packed {
    logic                 auto_bw;
    logic                 acquire_track_sel;
    logic                 lock_irq_enable;
    logic                 pll_power_on;
    logic                 base_clock_select;
    logic [`PLC_N_W-1:0]  mult_n;
    logic [`PLC_E_W-1:0]  range_e;
    logic [`PLC_L_W-1:0]  lin_l;
  } plc_cfg_s;

  // status shown to software
  typedef struct packed {
    logic                 acquire_track_sel;
    logic                 lock;
    logic                 pll_active;
    logic                 vco_selected;
  } plc_stat_s;

endpackage : plc_pkg

// file: rtl/plc_mod_div.sv
// plc_mod_div: modulo divider counting input edge events
// assumes: edge_i is a one-cycle event in the ref_clk_i domain
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_mod_div (
  input  wire logic                ref_clk_i,
  input  wire logic                arst_n_i,
  input  wire logic [`PLC_N_W-1:0] div_i,
  input  wire logic                edge_i,
  output logic                     tick_o,
  output logic                     level_o
);
  logic [`PLC_N_W-1:0] cnt_ff;
  logic [`PLC_N_W-1:0] nxt_cnt;
  logic                nxt_tick;
  logic                nxt_level;
  logic [`PLC_N_W:0]   eff;

  // divide by N, zero counts as one
  always_comb begin
    eff       = (div_i == '0) ? {{`PLC_N_W{1'b0}}, 1'b1} : {1'b0, div_i};
    nxt_cnt   = cnt_ff;
    nxt_tick  = 1'b0;
    if (edge_i) begin
      if ({1'b0, cnt_ff} >= eff - 1'b1) begin
        nxt_cnt  = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
    // divide by one has no half period, so the level pulses once per edge
    if (eff == {{`PLC_N_W{1'b0}}, 1'b1}) nxt_level = nxt_tick;
    else nxt_level = ({1'b0, nxt_cnt} < ((eff + 1'b1) >> 1));
  end

  // register count and outputs
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff  <= '0;
      tick_o  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_o  <= nxt_tick;
      level_o <= nxt_level;
    end
  end

  property p_tick_wraps;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    tick_o |-> cnt_ff == '0;
  endproperty
  a_tick_wraps: assert property (p_tick_wraps) else $error("divider tick without wrap");

  property p_zero_is_one;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (div_i == '0 && edge_i) |=> tick_o;
  endproperty
  a_zero_is_one: assert property (p_zero_is_one) else $error("zero divisor not one");

endmodule : plc_mod_div

// file: rtl/plc_phase_det.sv
// plc_phase_det: phase-frequency detector giving up and down correction pulses
// assumes: both ticks are one-cycle events in the ref_clk_i domain
`timescale 1ns/1ps
module plc_phase_det (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic enable_i,
  input  wire logic ref_tick_i,
  input  wire logic fb_tick_i,
  output logic      pump_up_o,
  output logic      pump_dn_o
);
  logic nxt_up;
  logic nxt_dn;

  // up spans reference edge to feedback edge, down the reverse
  always_comb begin
    nxt_up = pump_up_o;
    nxt_dn = pump_dn_o;
    if (!enable_i) begin
      nxt_up = 1'b0;
      nxt_dn = 1'b0;
    end else if (ref_tick_i && !fb_tick_i) begin
      if (pump_dn_o) nxt_dn = 1'b0;
      else nxt_up = 1'b1;
    end else if (fb_tick_i && !ref_tick_i) begin
      if (pump_up_o) nxt_up = 1'b0;
      else nxt_dn = 1'b1;
    end
  end

  // register the correction pulses
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pump_up_o <= 1'b0;
      pump_dn_o <= 1'b0;
    end else begin
      pump_up_o <= nxt_up;
      pump_dn_o <= nxt_dn;
    end
  end

  property p_one_direction;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !(pump_up_o && pump_dn_o);
  endproperty
  a_one_direction: assert property (p_one_direction) else $error("both pump directions");

  property p_ref_leads;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (enable_i && ref_tick_i && !fb_tick_i && !pump_dn_o) |=> pump_up_o;
  endproperty
  a_ref_leads: assert property (p_ref_leads) else $error("up pulse missing");

endmodule : plc_phase_det

// file: rtl/plc_loop_ctrl.sv
// plc_loop_ctrl: digital control of a clock-multiplying pll
// assumes: all clock inputs are sampled levels synchronous to ref_clk_i (25 MHz)
// Function
// - divide the vco clock by N to make the feedback clock.
// - phase detector emits up or down pulses sized by phase difference.
// - lock detector compares feedback and reference frequency to pick mode and lock.
// - acquisition mode shows the acquire/track bit clear.
// - filter tracks exactly when the acquire/track bit is set.
// - automatic bandwidth on lets the lock detector switch filter modes.
// - automatic mode acquire/track bit is read-only, set inside tolerance window.
// - automatic mode lock bit is read-only, set within tolerance.
// - automatic mode with irq enable raises interrupt on each lock toggle.
// - manual mode makes acquire/track bit a software control of filter mode.
// - manual mode disables lock bit and all interrupts.
// - locked vco runs at N times the reference frequency.
// - bus clock runs at a quarter of the selected clock.
// - vco center equals L times two to the E times 71.4 kHz.
// - N of zero acts as N of one.
// - L of zero disables the pll and blocks vco selection.
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_loop_ctrl (
  input  wire logic               ref_clk_i,
  input  wire logic               arst_n_i,
  input  wire plc_pkg::plc_cfg_s  cfg_i,
  input  wire logic               crystal_clock_i,
  input  wire logic               vco_output_clock_i,
  output plc_pkg::plc_stat_s      stat_o,
  output logic                    lock_irq_o,
  output logic                    filt_track_o,
  output logic                    pump_up_o,
  output logic                    pump_dn_o,
  output logic                    vco_feedback_clock_o,
  output logic                    base_clock_out_o,
  output logic                    bus_clock_o,
  output logic [`PLC_CTR_W-1:0]   vco_center_hz100_o
);
  plc_pkg::plc_ld_state_e state_ff;
  plc_pkg::plc_ld_state_e nxt_state;
  logic                   xtal_q_ff;
  logic                   vco_q_ff;
  logic                   xtal_rise;
  logic                   vco_rise;
  logic                   fb_tick;
  logic [4:0]             ref_cnt_ff;
  logic [4:0]             nxt_ref_cnt;
  logic [7:0]             fb_cnt_ff;
  logic [7:0]             nxt_fb_cnt;
  logic [7:0]             err;
  logic                   win_end;
  logic                   pll_active;
  logic                   acq_ff;
  logic                   nxt_acq;
  logic                   lock_ff;
  logic                   nxt_lock;
  logic                   irq_ff;
  logic                   nxt_irq;
  logic                   vco_sel_ff;
  logic                   nxt_vco_sel;
  logic                   src_rise;
  logic [`PLC_CTR_W-1:0]  ctr_ff;
  logic [`PLC_CTR_W-1:0]  nxt_ctr;

  // edge events of the sampled clock inputs
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xtal_q_ff <= 1'b0;
      vco_q_ff  <= 1'b0;
    end else begin
      xtal_q_ff <= crystal_clock_i;
      vco_q_ff  <= vco_output_clock_i;
    end
  end
  assign xtal_rise  = crystal_clock_i & ~xtal_q_ff;
  assign vco_rise   = vco_output_clock_i & ~vco_q_ff;
  assign pll_active = cfg_i.pll_power_on && (cfg_i.lin_l != '0);

  // feedback divider, vco over N
  plc_mod_div u_fb_div (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .div_i     (cfg_i.mult_n),
    .edge_i    (vco_rise & pll_active),
    .tick_o    (fb_tick),
    .level_o   (vco_feedback_clock_o)
  );

  // phase detector against the reference clock
  plc_phase_det u_pd (
    .ref_clk_i  (ref_clk_i),
    .arst_n_i   (arst_n_i),
    .enable_i   (pll_active),
    .ref_tick_i (xtal_rise),
    .fb_tick_i  (fb_tick),
    .pump_up_o  (pump_up_o),
    .pump_dn_o  (pump_dn_o)
  );

  // frequency window: count feedback ticks over a fixed number of reference ticks
  always_comb begin
    win_end     = xtal_rise && (ref_cnt_ff == `PLC_LD_LAST);
    nxt_ref_cnt = ref_cnt_ff;
    nxt_fb_cnt  = fb_cnt_ff;
    if (!pll_active) begin
      nxt_ref_cnt = '0;
      nxt_fb_cnt  = '0;
    end else begin
      if (xtal_rise) nxt_ref_cnt = win_end ? 5'h00 : ref_cnt_ff + 5'h01;
      if (win_end) nxt_fb_cnt = {7'h00, fb_tick};
      else if (fb_tick && fb_cnt_ff != `PLC_FB_MAX) nxt_fb_cnt = fb_cnt_ff + 8'h01;
    end
    // a locked loop gives one feedback tick per reference tick
    err = (fb_cnt_ff >= {3'h0, `PLC_LD_WINDOW}) ? fb_cnt_ff - {3'h0, `PLC_LD_WINDOW}
                                                 : {3'h0, `PLC_LD_WINDOW} - fb_cnt_ff;
  end

  // lock detector state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      plc_pkg::PLC_LD_OFF: begin
        if (pll_active) nxt_state = plc_pkg::PLC_LD_ACQUIRE;
      end
      plc_pkg::PLC_LD_ACQUIRE, plc_pkg::PLC_LD_TRACK, plc_pkg::PLC_LD_LOCKED: begin
        if (win_end) begin
          if (err > `PLC_ACQ_TOL) nxt_state = plc_pkg::PLC_LD_ACQUIRE;
          else if (err > `PLC_LOCK_TOL) nxt_state = plc_pkg::PLC_LD_TRACK;
          else nxt_state = plc_pkg::PLC_LD_LOCKED;
        end
      end
      default: nxt_state = plc_pkg::PLC_LD_OFF;
    endcase
    if (!pll_active) nxt_state = plc_pkg::PLC_LD_OFF;
  end

  // mode, lock indicator, interrupt, clock select and center value
  always_comb begin
    if (cfg_i.auto_bw) begin
      nxt_acq = (nxt_state == plc_pkg::PLC_LD_TRACK) || (nxt_state == plc_pkg::PLC_LD_LOCKED);
    end else begin
      nxt_acq = cfg_i.acquire_track_sel;
    end
    nxt_lock    = cfg_i.auto_bw && (nxt_state == plc_pkg::PLC_LD_LOCKED);
    nxt_irq     = cfg_i.auto_bw && cfg_i.lock_irq_enable && (nxt_lock != lock_ff);
    nxt_vco_sel = cfg_i.base_clock_select && pll_active;
    nxt_ctr     = `PLC_CTR_W'(({13'h0000, cfg_i.lin_l} * `PLC_FNOM_HZ100) << cfg_i.range_e);
  end

  // register detector, mode, indicator and center state
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff   <= plc_pkg::PLC_LD_OFF;
      ref_cnt_ff <= '0;
      fb_cnt_ff  <= '0;
      acq_ff     <= 1'b0;
      lock_ff    <= 1'b0;
      irq_ff     <= 1'b0;
      vco_sel_ff <= 1'b0;
      ctr_ff     <= '0;
    end else begin
      state_ff   <= nxt_state;
      ref_cnt_ff <= nxt_ref_cnt;
      fb_cnt_ff  <= nxt_fb_cnt;
      acq_ff     <= nxt_acq;
      lock_ff    <= nxt_lock;
      irq_ff     <= nxt_irq;
      vco_sel_ff <= nxt_vco_sel;
      ctr_ff     <= nxt_ctr;
    end
  end

  // base clock is the selected source over 2, bus clock over 4
  assign src_rise = vco_sel_ff ? vco_rise : xtal_rise;

  plc_mod_div u_base_div (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .div_i     (`PLC_BASE_DIV),
    .edge_i    (src_rise),
    .tick_o    (),
    .level_o   (base_clock_out_o)
  );

  plc_mod_div u_bus_div (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .div_i     (`PLC_BUS_DIV),
    .edge_i    (src_rise),
    .tick_o    (),
    .level_o   (bus_clock_o)
  );

  // outputs
  assign filt_track_o                = acq_ff;
  assign lock_irq_o                  = irq_ff;
  assign vco_center_hz100_o          = ctr_ff;
  assign stat_o.acquire_track_sel    = acq_ff;
  assign stat_o.lock                 = lock_ff;
  assign stat_o.pll_active           = state_ff != plc_pkg::PLC_LD_OFF;
  assign stat_o.vco_selected         = vco_sel_ff;

  property p_acq_clear;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cfg_i.auto_bw && $past(cfg_i.auto_bw) && state_ff == plc_pkg::PLC_LD_ACQUIRE) |-> !stat_o.acquire_track_sel;
  endproperty
  a_acq_clear: assert property (p_acq_clear) else $error("acquire mode with bit set");

  property p_track_mode;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ($past(cfg_i.auto_bw) && state_ff == plc_pkg::PLC_LD_TRACK) |-> filt_track_o;
  endproperty
  a_track_mode: assert property (p_track_mode) else $error("tracking state not tracking");

  property p_manual_ctrl;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !cfg_i.auto_bw |=> stat_o.acquire_track_sel == $past(cfg_i.acquire_track_sel);
  endproperty
  a_manual_ctrl: assert property (p_manual_ctrl) else $error("manual mode bit not followed");

  property p_lock_state;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    stat_o.lock |-> state_ff == plc_pkg::PLC_LD_LOCKED;
  endproperty
  a_lock_state: assert property (p_lock_state) else $error("lock without locked state");

  property p_manual_quiet;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !cfg_i.auto_bw |=> !stat_o.lock && !lock_irq_o;
  endproperty
  a_manual_quiet: assert property (p_manual_quiet) else $error("manual mode lock or irq");

  property p_irq_toggle;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    lock_irq_o |-> $past(cfg_i.lock_irq_enable) && (stat_o.lock != $past(stat_o.lock));
  endproperty
  a_irq_toggle: assert property (p_irq_toggle) else $error("irq without lock toggle");

  property p_window_out;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (pll_active && state_ff != plc_pkg::PLC_LD_OFF && win_end && err > `PLC_ACQ_TOL)
      |=> state_ff == plc_pkg::PLC_LD_ACQUIRE;
  endproperty
  a_window_out: assert property (p_window_out) else $error("out of tolerance not acquiring");

  property p_l_zero;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cfg_i.lin_l == '0) |=> state_ff == plc_pkg::PLC_LD_OFF && !stat_o.vco_selected;
  endproperty
  a_l_zero: assert property (p_l_zero) else $error("zero L left pll active");

  property p_center;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (cfg_i.lin_l == 8'h01 && cfg_i.range_e == 2'h1) |=> vco_center_hz100_o == 21'h000594;
  endproperty
  a_center: assert property (p_center) else $error("center frequency wrong");

  // an inactive loop drives no correction
  property p_off_quiet;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state_ff == plc_pkg::PLC_LD_OFF) |-> !pump_up_o && !pump_dn_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("pump active while pll off");

  property p_sel_needs_on;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    stat_o.vco_selected |-> $past(pll_active);
  endproperty
  a_sel_needs_on: assert property (p_sel_needs_on) else $error("vco selected while pll inactive");

  property p_locked_lock;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ($past(cfg_i.auto_bw) && state_ff == plc_pkg::PLC_LD_LOCKED) |-> stat_o.lock && filt_track_o;
  endproperty
  a_locked_lock: assert property (p_locked_lock) else $error("locked state without lock bit");

  property p_no_enable;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    !cfg_i.lock_irq_enable |=> !lock_irq_o;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("irq while not enabled");

  property p_toggle_irq;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ($past(cfg_i.auto_bw) && $past(cfg_i.lock_irq_enable) && stat_o.lock != $past(stat_o.lock)) |-> lock_irq_o;
  endproperty
  a_toggle_irq: assert property (p_toggle_irq) else $error("lock toggle without irq");

  // window counter never passes its last reference tick
  property p_ref_cnt_range;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ref_cnt_ff <= `PLC_LD_LAST;
  endproperty
  a_ref_cnt_range: assert property (p_ref_cnt_range) else $error("window counter out of range");

  property p_window_lock;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (pll_active && state_ff != plc_pkg::PLC_LD_OFF && win_end && err <= `PLC_LOCK_TOL)
      |=> state_ff == plc_pkg::PLC_LD_LOCKED;
  endproperty
  a_window_lock: assert property (p_window_lock) else $error("in tolerance not locked");

endmodule : plc_loop_ctrl

// file: tb/plc_clk_src.sv
// plc_clk_src: crystal and vco level sources sampled on ref_clk_i
// assumes: half periods of two or more ref_clk_i cycles
`timescale 1ns/1ps
module plc_clk_src (
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] xtal_half_i,
  input  wire logic [7:0] vco_half_i,
  input  wire logic       vco_run_i,
  output logic            crystal_clock_o,
  output logic            vco_output_clock_o
);
  logic [7:0] xt_cnt_ff;
  logic [7:0] vc_cnt_ff;

  // crystal runs free from reset on
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xt_cnt_ff       <= 8'h00;
      crystal_clock_o <= 1'b0;
    end else if (xt_cnt_ff >= xtal_half_i - 8'h01) begin
      xt_cnt_ff       <= 8'h00;
      crystal_clock_o <= ~crystal_clock_o;
    end else begin
      xt_cnt_ff <= xt_cnt_ff + 8'h01;
    end
  end

  // vco stands still while the loop is inactive
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vc_cnt_ff          <= 8'h00;
      vco_output_clock_o <= 1'b0;
    end else if (!vco_run_i) begin
      vc_cnt_ff <= 8'h00;
    end else if (vc_cnt_ff >= vco_half_i - 8'h01) begin
      vc_cnt_ff          <= 8'h00;
      vco_output_clock_o <= ~vco_output_clock_o;
    end else begin
      vc_cnt_ff <= vc_cnt_ff + 8'h01;
    end
  end
endmodule : plc_clk_src

// file: tb/test_plc_loop_ctrl.sv
// test_plc_loop_ctrl: directed test of the pll loop mode control
// assumes: plc_clk_src drives crystal and vco levels
`timescale 1ns/1ps
`include "plc_regs.svh"
module test_plc_loop_ctrl;
  logic                  ref_clk_i = 1'b0;
  logic                  arst_n_i  = 1'b0;
  plc_pkg::plc_cfg_s     cfg       = '0;
  logic [7:0]            vh        = 8'h08;
  logic                  xt;
  logic                  vc;
  plc_pkg::plc_stat_s    stat;
  logic                  irq, trk, up, dn, fb, base, bus;
  logic [`PLC_CTR_W-1:0] ctr;
  logic [5:0]            pv        = '0;
  int                    cnt[9]    = '{default: 0};
  int                    d[9];
  int                    s9[9];
  int                    miscompares = 0;
  int                    comparisons = 0;
  int                    cycles      = 0;
  logic [1:0]            te[5]     = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
  logic [7:0]            tl[5]     = '{8'h1B, 8'h45, 8'h62, 8'h01, 8'h00};
  int                    ns[3]     = '{0, 1, 3};

  plc_loop_ctrl plc_loop_ctrl_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cfg_i(cfg),
    .crystal_clock_i(xt), .vco_output_clock_i(vc), .stat_o(stat), .lock_irq_o(irq),
    .filt_track_o(trk), .pump_up_o(up), .pump_dn_o(dn), .vco_feedback_clock_o(fb),
    .base_clock_out_o(base), .bus_clock_o(bus), .vco_center_hz100_o(ctr));
  plc_clk_src plc_clk_src_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .xtal_half_i(8'h10),
    .vco_half_i(vh), .vco_run_i(stat.pll_active), .crystal_clock_o(xt), .vco_output_clock_o(vc));

  // 25 MHz clock
  always #20 ref_clk_i = ~ref_clk_i;

  // edge and pulse counters, plus the hang guard
  always @(posedge ref_clk_i) begin
    pv     <= {stat.lock, fb, vc, xt, bus, base};
    cnt[0] <= cnt[0] + irq;
    cnt[1] <= cnt[1] + (stat.lock ^ pv[5]);
    cnt[2] <= cnt[2] + up;
    cnt[3] <= cnt[3] + dn;
    cnt[4] <= cnt[4] + (fb & ~pv[4]);
    cnt[5] <= cnt[5] + (vc & ~pv[3]);
    cnt[6] <= cnt[6] + (xt & ~pv[2]);
    cnt[7] <= cnt[7] + (bus & ~pv[1]);
    cnt[8] <= cnt[8] + (base & ~pv[0]);
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  function automatic logic near(input int a, input int b, input int t);
    return (a >= b - t) && (a <= b + t);
  endfunction : near

  // wait n cycles, sampling at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc

  // count events over n cycles into d
  task automatic run(input int n);
    int s[9];
    s = cnt;
    cyc(n);
    foreach (d[i]) d[i] = cnt[i] - s[i];
  endtask : run

  // software control bits, changed on the rising edge
  task automatic mode(input logic aw, input logic at, input logic ie, input logic on, input logic bs);
    @(posedge ref_clk_i);
    cfg.auto_bw           <= aw;
    cfg.acquire_track_sel <= at;
    cfg.lock_irq_enable   <= ie;
    cfg.pll_power_on      <= on;
    cfg.base_clock_select <= bs;
  endtask : mode

  task automatic setv(input logic [7:0] v);
    @(posedge ref_clk_i);
    vh <= v;
  endtask : setv

  // main sequence
  initial begin
    cyc(5);
    chk("rst_stat", stat, 4'h0);
    chk("rst_bus", bus, 1'b0);
    @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    cfg.mult_n <= 12'h002;
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk_i);
      cfg.range_e <= te[k];
      cfg.lin_l   <= tl[k];
      cyc(3);
      chk("center", ctr, tl[k] * (1 << te[k]) * `PLC_FNOM_HZ100);
    end
    mode(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    cyc(4);
    chk("l0_active", stat.pll_active, 1'b0);
    chk("l0_vco_sel", stat.vco_selected, 1'b0);
    mode(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    @(posedge ref_clk_i);
    cfg.lin_l <= 8'h45;
    cyc(4);
    chk("off_vco_sel", stat.vco_selected, 1'b0);
    run(1024);
    chk("xt_bus", near(d[7] * 4, d[6], 4), 1'b1);
    chk("xt_base", near(d[8] * 2, d[6], 2), 1'b1);
    mode(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    cyc(100);
    chk("early_lock", stat.lock, 1'b0);
    chk("auto_ro_acq", stat.acquire_track_sel, 1'b0);
    cyc(1500);
    chk("lock", stat.lock, 1'b1);
    chk("lock_acq", stat.acquire_track_sel, 1'b1);
    chk("lock_trk", trk, 1'b1);
    run(1024);
    chk("fb_div", near(d[4] * 2, d[5], 2), 1'b1);
    s9 = cnt;
    setv(8'h07);
    cyc(1600);
    chk("trk_acq", stat.acquire_track_sel, 1'b1);
    chk("trk_lock", stat.lock, 1'b0);
    setv(8'h05);
    cyc(1600);
    chk("acq_acq", stat.acquire_track_sel, 1'b0);
    chk("acq_trk", trk, 1'b0);
    run(512);
    chk("pump_fast", d[3] > d[2], 1'b1);
    chk("irq_tog", cnt[0] - s9[0], cnt[1] - s9[1]);
    chk("tog_seen", cnt[1] - s9[1] > 0, 1'b1);
    setv(8'h0C);
    cyc(1100);
    run(512);
    chk("pump_slow", d[2] > d[3], 1'b1);
    mode(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    setv(8'h08);
    run(1600);
    chk("noie_tog", d[1] > 0, 1'b1);
    chk("noie_irq", d[0], 0);
    mode(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    cyc(4);
    chk("vco_sel", stat.vco_selected, 1'b1);
    run(1024);
    chk("vco_bus", near(d[7] * 4, d[5], 4), 1'b1);
    chk("vco_base", near(d[8] * 2, d[5], 2), 1'b1);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk_i);
      cfg.mult_n <= ns[k][11:0];
      run(512);
      chk("n_div", near(d[4] * (ns[k] == 0 ? 1 : ns[k]), d[5], 3), 1'b1);
    end
    mode(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge ref_clk_i);
    cfg.mult_n <= 12'h002;
    mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    cyc(3);
    chk("man_trk0", trk, 1'b0);
    chk("man_acq0", stat.acquire_track_sel, 1'b0);
    cyc(200);
    mode(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    cyc(3);
    chk("man_trk1", trk, 1'b1);
    cyc(200);
    mode(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    run(1600);
    chk("man_lock", stat.lock, 1'b0);
    chk("man_irq", d[0], 0);
    chk("man_vco_sel", stat.vco_selected, 1'b1);
    mode(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    cyc(3);
    chk("man_back", trk, 1'b0);
    final_report();
  end
endmodule : test_plc_loop_ctrl
